// ---- dwv_core_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Core side: instruction fetch bus, state and privilege levels
module dwv_core_model (
    input wire logic clk,
    output logic [31:0] instr_addr,
    output logic [31:0] instr_data,
    output logic instr_fetch,
    output logic instr_set_state_flag,
    output logic fetch_privilege_select,
    output logic exception_entry
);
    initial begin
        instr_addr = 32'h0000_0000;
        instr_data = 32'hffff_ffff;
        instr_fetch = 1'b0;
        instr_set_state_flag = 1'b0;
        fetch_privilege_select = 1'b0;
        exception_entry = 1'b0;
    end
    // Core state and privilege levels
    task automatic set_state(input logic s, input logic p);
        instr_set_state_flag = s;
        fetch_privilege_select = p;
    endtask
    // One fetch over one rising edge; idle bus then shows inverted junk
    task automatic fetch(input logic [31:0] a, input logic exc);
        @(negedge clk);
        instr_addr = a;
        instr_data = ~a;
        instr_fetch = 1'b1;
        exception_entry = exc;
        @(negedge clk);
        instr_fetch = 1'b0;
        exception_entry = 1'b0;
        instr_addr = ~a;
        instr_data = a;
    endtask
endmodule
`default_nettype wire

// ---- dwv_debug_watch.sv ----
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R01] Mode bit zero: comparators watch instruction address, data and control.
// [R02] Debugger writes 1 into control mask bits 2 and 0 in instruction mode.
// [R03] Instruction control layout: enable, range, chain, extern, privilege, mode, state.
// [R04] State bit matches compressed fetches at one, standard fetches at zero.
// [R05] Privilege bit matches user fetches at zero, privileged fetches at one.
// [R06] Each watchpoint compares its own external condition input.
// [R07] Unit 1 chain output is a latch gated by address/control, loaded with data.
// [R08] Chain latch clears on control value write and while test reset low.
// [R09] Unit 1 address comparator drives unit 0 range input.
// [R10] Breakpoint only when enable set; enable bit is never masked.
// [R11] Debug control: step, interrupt disable, debug request, debug acknowledge.
// [R12] Five-bit status is read only; writes ignored, reads return status.
// [R13] Status bits 1 and 0 give synchronised request and acknowledge.
// [R14] Status bit 2 gives interrupt enable built from synchronised acknowledge.
// [R15] Status bit 3 gives synchronised system access completion.
// [R16] Status bit 4 gives instruction set state.
// [R17] Vector trap bits: fast interrupt, interrupt, reserved, aborts, software interrupt, undef, reset.
// [R18] Trapped exception enters debug as if breakpointed on its vector fetch.
// [R19] Exception-entry vector fetch forces the internal breakpoint high.
// [R20] Vector trapping uses neither watchpoint comparator.
// [R21] Plain branches into the vector area never trigger a trap.
// [R22] Mode bit one: comparators watch data address, data and data control.
// [R23] Mask bit one removes that value bit from comparison.
// [R24] Step bit set on debug exit: one instruction runs, then debug again.
// [R25] Reserved trap bit and unused control bits read zero, do nothing.
module dwv_debug_watch (
    input wire logic clk,
    input wire logic nrst,
    input wire logic reg_sel,
    input wire logic reg_write,
    input wire logic [4:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [31:0] instr_addr,
    input wire logic [31:0] instr_data,
    input wire logic instr_fetch,
    input wire logic instr_set_state_flag,
    input wire logic fetch_privilege_select,
    input wire logic exception_entry,
    input wire logic [31:0] data_addr,
    input wire logic [31:0] data_bus,
    input wire logic data_access,
    input wire logic data_write,
    input wire logic [1:0] data_size,
    input wire logic data_privilege_select,
    input wire logic external_condition_wp0,
    input wire logic external_condition_wp1,
    input wire logic test_reset_n,
    input wire logic debug_request_ext,
    input wire logic debug_acknowledge,
    input wire logic system_access_complete,
    output logic internal_breakpoint,
    output logic internal_watchpoint,
    output logic debug_request,
    output logic debug_ack_force,
    output logic interrupt_disable
);
    localparam int NSYNC = 5;

    logic [3:0] dctl;
    logic [7:0] vtrap;
    logic [31:0] aval [dwv_pkg::DWV_NWP];
    logic [31:0] amsk [dwv_pkg::DWV_NWP];
    logic [31:0] dval [dwv_pkg::DWV_NWP];
    logic [31:0] dmsk [dwv_pkg::DWV_NWP];
    logic [8:0] cval [dwv_pkg::DWV_NWP];
    logic [7:0] cmsk [dwv_pkg::DWV_NWP];
    logic [dwv_pkg::DWV_NWP-1:0] wp_addr_hit;
    logic [dwv_pkg::DWV_NWP-1:0] wp_ac_hit;
    logic [dwv_pkg::DWV_NWP-1:0] wp_data_hit;
    logic [dwv_pkg::DWV_NWP-1:0] wp_hit;
    logic [dwv_pkg::DWV_NWP-1:0] wp_en;
    logic [dwv_pkg::DWV_NWP-1:0] wp_dmode;
    logic [dwv_pkg::DWV_NWP-1:0] wr_cval;
    logic chain_latch;
    logic [NSYNC-1:0] sync_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic trst_s;
    logic req_s;
    logic ack_s;
    logic done_s;
    logic iset_s;
    logic [4:0] status;
    logic wr_en;
    logic rd_en;
    logic [31:0] next_rdata;
    logic [31:0] wp_rdata [dwv_pkg::DWV_NWP];
    logic [dwv_pkg::DWV_NWP-1:0] wp_rsel;
    logic [2:0] vec_idx;
    logic in_vec_area;
    logic vec_hit;
    logic wp_bkpt;
    logic wp_wpt;
    logic ack_q;
    logic leave_debug;
    logic step_hit;
    dwv_pkg::dwv_step_t ss_state;
    dwv_pkg::dwv_step_t next_ss_state;

    // Register port strobes
    assign wr_en = reg_sel && reg_write;
    assign rd_en = reg_sel && !reg_write;

    // Two-flop synchronisers for status and test reset
    assign sync_in = {test_reset_n, debug_request_ext, debug_acknowledge,
        system_access_complete, instr_set_state_flag};
    for (genvar s = 0; s < NSYNC; s++) begin : gen_sync
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                sync_a[s] <= 1'b0;
                sync_b[s] <= 1'b0;
            end else begin
                sync_a[s] <= sync_in[s];
                sync_b[s] <= sync_a[s];
            end
        end
    end
    assign {trst_s, req_s, ack_s, done_s, iset_s} = sync_b;

    // Status word, assembled from synchronised inputs
    assign status = {iset_s, // R16
        done_s, // R15
        !(dctl[dwv_pkg::DWV_DC_IRQ_OFF] || ack_s), // R14
        req_s || dctl[dwv_pkg::DWV_DC_REQ], // R13
        ack_s}; // R13

    // Watchpoint units and their register files
    for (genvar g = 0; g < dwv_pkg::DWV_NWP; g++) begin : gen_wp
        logic [4:0] base;
        dwv_wp_if w ();
        dwv_wp_unit u_unit (
            .w(w)
        );
        assign base = dwv_pkg::DWV_WP_BASE[g];
        assign w.ia = instr_addr;
        assign w.id = instr_data;
        assign w.ivalid = instr_fetch;
        assign w.iset = instr_set_state_flag; // R04
        assign w.ipriv = fetch_privilege_select; // R05
        assign w.da = data_addr;
        assign w.dd = data_bus;
        assign w.dvalid = data_access;
        assign w.dnrw = data_write;
        assign w.dmas = data_size;
        assign w.dpriv = data_privilege_select;
        assign w.ext = (g == 0) ? external_condition_wp0 : external_condition_wp1; // R06
        assign w.chain_in = (g == 0) ? chain_latch : 1'b0; // R07
        assign w.range_in = (g == 0) ? wp_addr_hit[1] : 1'b0; // R09
        assign w.aval = aval[g];
        assign w.amsk = amsk[g];
        assign w.dval = dval[g];
        assign w.dmsk = dmsk[g];
        assign w.cval = cval[g];
        assign w.cmsk = cmsk[g];
        assign wp_addr_hit[g] = w.addr_hit;
        assign wp_ac_hit[g] = w.ac_hit;
        assign wp_data_hit[g] = w.data_hit;
        assign wp_hit[g] = w.hit;
        assign wp_en[g] = cval[g][dwv_pkg::DWV_CB_ENABLE];
        assign wp_dmode[g] = cval[g][dwv_pkg::DWV_CB_MODE];
        assign wr_cval[g] = wr_en && (reg_addr == (base | dwv_pkg::DWV_OFF_CVAL));
        assign wp_rsel[g] = (reg_addr & ~dwv_pkg::DWV_OFF_AMSK & ~dwv_pkg::DWV_OFF_DVAL
            & ~dwv_pkg::DWV_OFF_CVAL) == base;
        assign wp_rdata[g] =
            (reg_addr == (base | dwv_pkg::DWV_OFF_AVAL)) ? aval[g] :
            (reg_addr == (base | dwv_pkg::DWV_OFF_AMSK)) ? amsk[g] :
            (reg_addr == (base | dwv_pkg::DWV_OFF_DVAL)) ? dval[g] :
            (reg_addr == (base | dwv_pkg::DWV_OFF_DMSK)) ? dmsk[g] :
            (reg_addr == (base | dwv_pkg::DWV_OFF_CVAL)) ? {23'h000000, cval[g]} :
            (reg_addr == (base | dwv_pkg::DWV_OFF_CMSK)) ? {24'h000000, cmsk[g]} :
            32'h0000_0000;

        // Value and mask register writes
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                aval[g] <= dwv_pkg::DWV_WORD_RST;
                amsk[g] <= dwv_pkg::DWV_WORD_RST;
                dval[g] <= dwv_pkg::DWV_WORD_RST;
                dmsk[g] <= dwv_pkg::DWV_WORD_RST;
                cval[g] <= dwv_pkg::DWV_CVAL_RST;
                cmsk[g] <= dwv_pkg::DWV_CMSK_RST;
            end else if (wr_en) begin
                if (reg_addr == (base | dwv_pkg::DWV_OFF_AVAL)) aval[g] <= reg_wdata;
                if (reg_addr == (base | dwv_pkg::DWV_OFF_AMSK)) amsk[g] <= reg_wdata;
                if (reg_addr == (base | dwv_pkg::DWV_OFF_DVAL)) dval[g] <= reg_wdata;
                if (reg_addr == (base | dwv_pkg::DWV_OFF_DMSK)) dmsk[g] <= reg_wdata;
                if (wr_cval[g]) cval[g] <= reg_wdata[8:0];
                if (reg_addr == (base | dwv_pkg::DWV_OFF_CMSK)) cmsk[g] <= reg_wdata[7:0];
            end
        end
    end

    // Chain latch: unit 1 address/control gates, unit 1 data loads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            chain_latch <= 1'b0;
        end else if (wr_cval[1] || !trst_s) begin
            chain_latch <= 1'b0; // R08
        end else if (wp_ac_hit[1]) begin
            chain_latch <= wp_data_hit[1]; // R07
        end
    end

    // Debug control and vector trap registers; status ignores writes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dctl <= dwv_pkg::DWV_DCTL_RST;
            vtrap <= dwv_pkg::DWV_VTRAP_RST;
        end else if (wr_en && reg_addr == dwv_pkg::DWV_ADDR_DCTL) begin
            dctl <= reg_wdata[3:0]; // R11
        end else if (wr_en && reg_addr == dwv_pkg::DWV_ADDR_VTRAP) begin
            vtrap <= reg_wdata[7:0] & ~(8'h01 << dwv_pkg::DWV_VT_RESERVED); // R17 R25
        end
    end

    // Read selection
    assign next_rdata =
        (reg_addr == dwv_pkg::DWV_ADDR_DCTL) ? {28'h0000000, dctl} :
        (reg_addr == dwv_pkg::DWV_ADDR_DSTAT) ? {27'h0000000, status} : // R12
        (reg_addr == dwv_pkg::DWV_ADDR_VTRAP) ? {24'h000000, vtrap} :
        wp_rsel[0] ? wp_rdata[0] :
        wp_rsel[1] ? wp_rdata[1] :
        32'h0000_0000;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (rd_en) begin
            reg_rdata <= next_rdata;
        end
    end

    // Vector trap decode, separate from the comparators
    assign vec_idx = instr_addr[dwv_pkg::DWV_VEC_IDX_HI:dwv_pkg::DWV_VEC_IDX_LO];
    assign in_vec_area = (instr_addr[31:dwv_pkg::DWV_VEC_TOP_LO] == 27'h0000000);
    assign vec_hit = instr_fetch && exception_entry && in_vec_area && vtrap[vec_idx]; // R18 R19 R20 R21

    // Enabled watchpoint hits
    assign wp_bkpt = |(wp_hit & wp_en & ~wp_dmode); // R10
    assign wp_wpt = |(wp_hit & wp_en & wp_dmode); // R10

    // Single-step sequencer
    assign leave_debug = ack_q && !debug_acknowledge;
    assign step_hit = (ss_state == dwv_pkg::DWV_SS_STOP) && instr_fetch;
    always_comb begin
        next_ss_state = ss_state;
        case (ss_state)
            dwv_pkg::DWV_SS_IDLE: begin
                if (leave_debug && dctl[dwv_pkg::DWV_DC_STEP]) begin
                    next_ss_state = dwv_pkg::DWV_SS_RUN; // R24
                end
            end
            dwv_pkg::DWV_SS_RUN: begin
                if (debug_acknowledge) begin
                    next_ss_state = dwv_pkg::DWV_SS_IDLE;
                end else if (instr_fetch) begin
                    next_ss_state = dwv_pkg::DWV_SS_STOP; // R24
                end
            end
            dwv_pkg::DWV_SS_STOP: begin
                if (debug_acknowledge || instr_fetch) begin
                    next_ss_state = dwv_pkg::DWV_SS_IDLE;
                end
            end
            default: begin
                next_ss_state = dwv_pkg::DWV_SS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ss_state <= dwv_pkg::DWV_SS_IDLE;
            ack_q <= 1'b0;
        end else begin
            ss_state <= next_ss_state;
            ack_q <= debug_acknowledge;
        end
    end

    // Registered breakpoint and watchpoint outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            internal_breakpoint <= 1'b0;
            internal_watchpoint <= 1'b0;
        end else begin
            internal_breakpoint <= wp_bkpt || vec_hit || step_hit; // R10 R19 R24
            internal_watchpoint <= wp_wpt;
        end
    end

    // Control outputs to the core
    assign debug_request = dctl[dwv_pkg::DWV_DC_REQ]; // R11
    assign debug_ack_force = dctl[dwv_pkg::DWV_DC_ACK]; // R11
    assign interrupt_disable = dctl[dwv_pkg::DWV_DC_IRQ_OFF] || debug_acknowledge; // R11

    // Checks
    AST_BKPT_CAUSE: assert property (@(posedge clk) disable iff (!nrst) // R10
        internal_breakpoint |-> $past(wp_bkpt || vec_hit || step_hit))
        else $error("breakpoint without a cause");
    AST_VEC_FORCE: assert property (@(posedge clk) disable iff (!nrst) // R19
        vec_hit |=> internal_breakpoint)
        else $error("trapped vector fetch gave no breakpoint");
    AST_NO_PLAIN_BRANCH: assert property (@(posedge clk) disable iff (!nrst) // R21
        (instr_fetch && !exception_entry && !wp_bkpt && !step_hit) |=> !internal_breakpoint)
        else $error("plain fetch forced a breakpoint");
    AST_CHAIN_CLEAR: assert property (@(posedge clk) disable iff (!nrst) // R08
        wr_cval[1] |=> !chain_latch)
        else $error("chain latch not cleared on control write");
    AST_CHAIN_LOAD: assert property (@(posedge clk) disable iff (!nrst) // R07
        (wp_ac_hit[1] && !wr_cval[1] && trst_s) |=> chain_latch == $past(wp_data_hit[1]))
        else $error("chain latch did not load data result");
    AST_STATUS_RO: assert property (@(posedge clk) disable iff (!nrst) // R12
        (wr_en && reg_addr == dwv_pkg::DWV_ADDR_DSTAT) |=> $stable(dctl) && $stable(vtrap))
        else $error("status write changed a register");
    AST_STATUS_READ: assert property (@(posedge clk) disable iff (!nrst) // R13
        (rd_en && reg_addr == dwv_pkg::DWV_ADDR_DSTAT)
        |=> reg_rdata[1:0] == $past({req_s || dctl[dwv_pkg::DWV_DC_REQ], ack_s}))
        else $error("status read returned wrong request or acknowledge");
    AST_STEP_ENTER: assert property (@(posedge clk) disable iff (!nrst) // R24
        (ss_state == dwv_pkg::DWV_SS_IDLE && leave_debug && dctl[dwv_pkg::DWV_DC_STEP])
        |=> ss_state == dwv_pkg::DWV_SS_RUN)
        else $error("single step not armed on debug exit");
    AST_STEP_STOP: assert property (@(posedge clk) disable iff (!nrst) // R24
        step_hit |=> internal_breakpoint ##1 ss_state == dwv_pkg::DWV_SS_IDLE)
        else $error("single step did not stop after one instruction");
    AST_ISET_MATCH: assert property (@(posedge clk) disable iff (!nrst) // R04
        (!wp_dmode[0] && !cmsk[0][dwv_pkg::DWV_CB_ISET]
        && instr_set_state_flag != cval[0][dwv_pkg::DWV_CB_ISET]) |-> !wp_ac_hit[0])
        else $error("state bit mismatch still matched");
    AST_ENABLE_GATE: assert property (@(posedge clk) disable iff (!nrst) // R10
        (!wp_en[0] && !wp_en[1] && !vec_hit && !step_hit) |=> !internal_breakpoint)
        else $error("disabled watchpoint raised breakpoint");

    COV_VEC: cover property (@(posedge clk) disable iff (!nrst) vec_hit ##1 internal_breakpoint);
    COV_CHAIN: cover property (@(posedge clk) disable iff (!nrst) chain_latch && wp_hit[0]);
    COV_RANGE: cover property (@(posedge clk) disable iff (!nrst) wp_addr_hit[1] && wp_hit[0]);
    COV_STEP: cover property (@(posedge clk) disable iff (!nrst)
        ss_state == dwv_pkg::DWV_SS_RUN ##[1:20] step_hit);
endmodule
`default_nettype wire

// ---- dwv_pkg.sv ----
package dwv_pkg;
    // Watchpoint count and register map of the debug port
    localparam int DWV_NWP = 2;
    localparam logic [4:0] DWV_ADDR_DCTL = 5'h00;
    localparam logic [4:0] DWV_ADDR_DSTAT = 5'h01;
    localparam logic [4:0] DWV_ADDR_VTRAP = 5'h02;
    localparam logic [4:0] DWV_WP_BASE [DWV_NWP] = '{5'h08, 5'h10};
    localparam logic [4:0] DWV_OFF_AVAL = 5'h00;
    localparam logic [4:0] DWV_OFF_AMSK = 5'h01;
    localparam logic [4:0] DWV_OFF_DVAL = 5'h02;
    localparam logic [4:0] DWV_OFF_DMSK = 5'h03;
    localparam logic [4:0] DWV_OFF_CVAL = 5'h04;
    localparam logic [4:0] DWV_OFF_CMSK = 5'h05;

    // Register widths
    localparam int DWV_DCTL_W = 4;
    localparam int DWV_DSTAT_W = 5;
    localparam int DWV_VTRAP_W = 8;
    localparam int DWV_CVAL_W = 9;
    localparam int DWV_CMSK_W = 8;

    // Watchpoint control field positions
    localparam int DWV_CB_ENABLE = 8;
    localparam int DWV_CB_RANGE = 7;
    localparam int DWV_CB_CHAIN = 6;
    localparam int DWV_CB_EXTERN = 5;
    localparam int DWV_CB_PRIV = 4;
    localparam int DWV_CB_MODE = 3;
    localparam int DWV_CB_ISET = 1;
    localparam logic [7:0] DWV_IMODE_DONT_CARE = 8'h05;
    localparam logic [7:0] DWV_CMSK_UNMASKABLE = 8'h08;

    // Debug control and status field positions
    localparam int DWV_DC_STEP = 3;
    localparam int DWV_DC_IRQ_OFF = 2;
    localparam int DWV_DC_REQ = 1;
    localparam int DWV_DC_ACK = 0;

    // Exception vector area and reserved trap slot
    localparam int DWV_VEC_TOP_LO = 5;
    localparam int DWV_VEC_IDX_HI = 4;
    localparam int DWV_VEC_IDX_LO = 2;
    localparam logic [2:0] DWV_VT_RESERVED = 3'h5;

    // Reset values
    localparam logic [3:0] DWV_DCTL_RST = 4'h0;
    localparam logic [7:0] DWV_VTRAP_RST = 8'h00;
    localparam logic [31:0] DWV_WORD_RST = 32'h0000_0000;
    localparam logic [8:0] DWV_CVAL_RST = 9'h000;
    localparam logic [7:0] DWV_CMSK_RST = 8'h00;

    // Single-step sequencer states
    typedef enum logic [2:0] {
        DWV_SS_IDLE = 3'b001,
        DWV_SS_RUN = 3'b010,
        DWV_SS_STOP = 3'b100
    } dwv_step_t;
endpackage

// ---- dwv_wp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface dwv_wp_if;
    logic [31:0] ia;
    logic [31:0] id;
    logic ivalid;
    logic iset;
    logic ipriv;
    logic [31:0] da;
    logic [31:0] dd;
    logic dvalid;
    logic dnrw;
    logic [1:0] dmas;
    logic dpriv;
    logic ext;
    logic chain_in;
    logic range_in;
    logic [31:0] aval;
    logic [31:0] amsk;
    logic [31:0] dval;
    logic [31:0] dmsk;
    logic [8:0] cval;
    logic [7:0] cmsk;
    logic addr_hit;
    logic ac_hit;
    logic data_hit;
    logic hit;
    modport unit (
        input ia, id, ivalid, iset, ipriv, da, dd, dvalid, dnrw, dmas, dpriv,
        input ext, chain_in, range_in, aval, amsk, dval, dmsk, cval, cmsk,
        output addr_hit, ac_hit, data_hit, hit
    );
    modport ctrl (
        output ia, id, ivalid, iset, ipriv, da, dd, dvalid, dnrw, dmas, dpriv,
        output ext, chain_in, range_in, aval, amsk, dval, dmsk, cval, cmsk,
        input addr_hit, ac_hit, data_hit, hit
    );
endinterface
`default_nettype wire

// ---- dwv_wp_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module dwv_wp_unit (
    dwv_wp_if.unit w
);
    logic mode;
    logic [31:0] addr;
    logic [31:0] data;
    logic valid;
    logic [7:0] obs;
    logic [7:0] ctl_msk;

    // Bus selection by the mode bit
    assign mode = w.cval[dwv_pkg::DWV_CB_MODE];
    assign addr = mode ? w.da : w.ia; // R01 R22
    assign data = mode ? w.dd : w.id; // R01 R22
    assign valid = mode ? w.dvalid : w.ivalid;

    // Observed control vector in register layout
    assign obs = mode ?
        {w.range_in, w.chain_in, w.ext, w.dpriv, 1'b1, w.dmas, w.dnrw} : // R22
        {w.range_in, w.chain_in, w.ext, w.ipriv, 1'b0, 1'b0, w.iset, 1'b0}; // R03 R04 R05 R06

    // Mode bit never masked; unused instruction bits are ignored
    assign ctl_msk = (w.cmsk & ~dwv_pkg::DWV_CMSK_UNMASKABLE) |
        (mode ? 8'h00 : dwv_pkg::DWV_IMODE_DONT_CARE); // R25

    // Masked comparators
    assign w.addr_hit = valid && (((addr ^ w.aval) & ~w.amsk) == 32'h0000_0000); // R23
    assign w.data_hit = valid && (((data ^ w.dval) & ~w.dmsk) == 32'h0000_0000); // R23
    assign w.ac_hit = w.addr_hit && (((obs ^ w.cval[7:0]) & ~ctl_msk) == 8'h00);
    assign w.hit = w.ac_hit && w.data_hit;
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [4:0] U0 = dwv_pkg::DWV_WP_BASE[0];
    localparam logic [4:0] U1 = dwv_pkg::DWV_WP_BASE[1];
    localparam logic [4:0] DC = dwv_pkg::DWV_ADDR_DCTL;
    localparam logic [4:0] DS = dwv_pkg::DWV_ADDR_DSTAT;
    localparam logic [4:0] VT = dwv_pkg::DWV_ADDR_VTRAP;
    logic clk = 1'b0, nrst = 1'b0, reg_sel = 1'b0, reg_write = 1'b0, ext0 = 1'b0, ext1 = 1'b0;
    logic trst_n = 1'b0, dbg_ext = 1'b0, ack = 1'b0, sys_done = 1'b0, rd_seen = 1'b0;
    logic bk_seen = 1'b0, d_acc = 1'b0, d_wr = 1'b0, d_pr = 1'b0, i_fetch, st, pr, exc;
    logic bkpt, wpt, dbg_rq, ack_force, int_dis, wt_seen = 1'b0, wm = 1'b0;
    logic [1:0] d_size = 2'h0;
    logic [4:0] reg_addr = 5'h00;
    logic [31:0] reg_wdata = 32'h0, d_addr = 32'h0, d_bus = 32'h0, lfsr = 32'h29082f74;
    logic [31:0] reg_rdata, i_addr, i_data, a;
    logic [31:0] rq[$], bq[$];
    int fails = 0, check_count = 0, cycles = 0;
    int pos[4] = '{1, 4, 5, 7};
    dwv_debug_watch i_dwv_debug_watch (.clk(clk), .nrst(nrst), .reg_sel(reg_sel),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .instr_addr(i_addr), .instr_data(i_data), .instr_fetch(i_fetch),
        .instr_set_state_flag(st), .fetch_privilege_select(pr), .exception_entry(exc),
        .data_addr(d_addr), .data_bus(d_bus), .data_access(d_acc), .data_write(d_wr),
        .data_size(d_size), .data_privilege_select(d_pr), .external_condition_wp0(ext0),
        .external_condition_wp1(ext1), .test_reset_n(trst_n), .debug_request_ext(dbg_ext),
        .debug_acknowledge(ack), .system_access_complete(sys_done), .internal_breakpoint(bkpt),
        .internal_watchpoint(wpt), .debug_request(dbg_rq), .debug_ack_force(ack_force),
        .interrupt_disable(int_dis));
    dwv_core_model i_dwv_core_model (.clk(clk), .instr_addr(i_addr), .instr_data(i_data),
        .instr_fetch(i_fetch), .instr_set_state_flag(st), .fetch_privilege_select(pr),
        .exception_entry(exc));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Random data-side traffic
    always @(negedge clk) begin
        lfsr <= nxt(lfsr);
        d_addr <= lfsr;
        d_bus <= ~lfsr;
        d_acc <= lfsr[3];
        d_wr <= lfsr[5];
        d_size <= lfsr[7:6];
        d_pr <= lfsr[9];
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // One register access, strobe held over one rising edge
    task automatic acc(input logic w, input logic [4:0] ad, input logic [31:0] d);
        @(negedge clk);
        reg_sel = 1'b1;
        reg_write = w;
        reg_addr = ad;
        reg_wdata = d;
        @(negedge clk);
        reg_sel = 1'b0;
    endtask
    task automatic rd(input logic [4:0] ad, input logic [31:0] e);
        rq.push_back(e);
        acc(1'b0, ad, 32'h0);
    endtask
    task automatic fx(input logic [31:0] ad, input logic ex, input logic e);
        bq.push_back({31'h0, e});
        i_dwv_core_model.fetch(ad, ex);
    endtask
    // Note which strobes must produce a result on the next cycle
    always @(posedge clk) begin
        rd_seen <= reg_sel & ~reg_write;
        bk_seen <= i_fetch;
        wt_seen <= d_acc & wm;
    end
    // Compare results against the oldest note; cut a hang short
    always @(negedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            summarize();
        end else begin
            if (rd_seen) check("reg_rdata", reg_rdata, rq.pop_front());
            check("internal_breakpoint", {31'h0, bkpt}, bk_seen ? bq.pop_front() : 32'h0);
            check("internal_watchpoint", {31'h0, wpt}, {31'h0, wt_seen});
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        trst_n = 1'b1;
        rd(DC, 32'h0);
        rd(VT, 32'h0);
        wr_rd_ctl: begin
            acc(1'b1, DC, 32'h6);
            rd(DC, 32'h6);
            check("debug_request", {31'h0, dbg_rq}, 32'h1);
            check("debug_ack_force", {31'h0, ack_force}, 32'h0);
            check("interrupt_disable", {31'h0, int_dis}, 32'h1);
            acc(1'b1, DC, 32'h0);
            rd(5'h1f, 32'h0);
        end
        $display("test registers done");
        // Unit 0 masks address bit 3; unit 1 matches the exact address
        a = (lfsr & 32'hffff_ff00) | 32'h100;
        acc(1'b1, U0, a);
        acc(1'b1, U0 + 5'h1, 32'h8);
        acc(1'b1, U0 + 5'h3, 32'hffff_ffff);
        acc(1'b1, U1, a);
        foreach (pos[k]) for (int v = 0; v < 2; v++) begin
            acc(1'b1, U0 + 5'h4, 32'h100 | (32'h1 << pos[k]));
            acc(1'b1, U0 + 5'h5, 32'hff ^ (32'h1 << pos[k]));
            i_dwv_core_model.set_state(pos[k] == 1 && v == 1, pos[k] == 4 && v == 1);
            ext0 = (pos[k] == 5 && v == 1);
            ext1 = ~ext0;
            fx(a ^ ((pos[k] == 7 && v == 1) ? 32'h0 : 32'h8), 1'b0, v == 1);
        end
        acc(1'b1, U0 + 5'h4, 32'h1b2);
        acc(1'b1, U0 + 5'h5, 32'h4d);
        i_dwv_core_model.set_state(1'b1, 1'b1);
        ext0 = 1'b1;
        fx(a, 1'b0, 1'b1);
        fx(a ^ 32'h4, 1'b0, 1'b0);
        fx(a ^ 32'h8, 1'b0, 1'b0);
        acc(1'b1, U0 + 5'h4, 32'h0b2);
        fx(a, 1'b0, 1'b0);
        // Unit 1 in data mode with every mask set fires on each data access
        acc(1'b1, U1 + 5'h1, 32'hffff_ffff);
        acc(1'b1, U1 + 5'h3, 32'hffff_ffff);
        acc(1'b1, U1 + 5'h5, 32'hff);
        acc(1'b1, U1 + 5'h4, 32'h108);
        wm = 1'b1;
        repeat (16) @(negedge clk);
        acc(1'b1, U1 + 5'h4, 32'h0);
        wm = 1'b0;
        $display("test watchpoints done");
        acc(1'b1, VT, 32'hff);
        rd(VT, 32'hdf);
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, VT, 32'h1 << i);
            fx(32'(i * 4), 1'b1, i != 5);
            fx(32'(((i + 1) % 8) * 4), 1'b1, 1'b0);
            fx(32'(i * 4), 1'b0, 1'b0);
        end
        $display("test vector trap done");
        dbg_ext = 1'b1;
        sys_done = 1'b1;
        i_dwv_core_model.set_state(1'b1, 1'b0);
        repeat (4) @(negedge clk);
        acc(1'b1, DS, 32'h0);
        rd(DS, 32'h1e);
        dbg_ext = 1'b0;
        sys_done = 1'b0;
        acc(1'b1, DC, 32'h8);
        ack = 1'b1;
        i_dwv_core_model.set_state(1'b0, 1'b0);
        repeat (4) @(negedge clk);
        check("interrupt_disable", {31'h0, int_dis}, 32'h1);
        rd(DS, 32'h01);
        ack = 1'b0;
        // Step armed on debug exit: first fetch runs, second one breaks
        fx(a, 1'b0, 1'b0);
        fx(a ^ 32'h4, 1'b0, 1'b1);
        $display("test status done");
        repeat (3) @(negedge clk);
        summarize();
    end
endmodule
`default_nettype wire
